// >>> rtl/flash_read_device.sv
// Embedded flash read command engine, link and core sides
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Fast array read 0x0B, eight dummy cycles
// - Random array read 0x03, no dummy cycles
// - 0x53/0x55 copy one page into buffer
// - Fast buffer reads 0xD4/0xD6 with dummy cycles
// - Slow buffer reads 0xD1/0xD3 without dummy cycles
// - Single buffer variant rejects second-buffer codes
// - Master lowers select while clock high
// - Master sends opcode MSB first
// - Master sends 24-bit address MSB first
// - Any byte of any page may start
// - Eight dummy clocks, input ignored meanwhile
// - First data bit on falling edge after latency
// - New bit each falling edge, address increments
// - Master raises select on falling edge
// - Select held low for whole transfer
// - Array page end continues at next page, buffer end wraps to byte 0
// - Array end wraps to page zero
// - Select rise aborts read, output high
// - Array reads leave buffers untouched
// - Random read data straight after address
// - Copy self-timed after select rise, ready flag
module flash_read_device
   import flash_read_pkg::*;
#(
   parameter bit TWO_BUFFERS = 1'b1        // Second page buffer present
) (
   input  wire logic              clock,     // Core clock
   input  wire logic              rst,       // Core reset
   input  wire logic              mem_we,    // Array load strobe
   input  wire logic [PAGE_W-1:0] mem_page,  // Array load page
   input  wire logic [BYTE_W-1:0] mem_byte,  // Array load byte
   input  wire logic [7:0]        mem_wdata, // Array load data
   output logic                   ready,     // Copy idle, status bit 7
   spi_link_if.device             link       // Serial link
);

   //////////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0] mem   [NUM_PAGES][PAGE_BYTES];
   logic [7:0] bufm  [2][PAGE_BYTES];

   // Link side state
   logic [5:0]        hdr_cnt;
   logic [31:0]       hdr_sr;
   logic              started;
   logic [2:0]        bit_idx;
   logic [PAGE_W-1:0] rd_page;
   logic [BYTE_W-1:0] rd_byte;
   logic              rd_buf;
   logic              rd_bsel;
   logic              miso_q;
   logic              copy_tgl;
   logic [PAGE_W-1:0] copy_page;
   logic              copy_bsel;

   // Core side state
   logic [2:0]        tgl_s;
   logic [1:0]        sel_s;
   logic              armed;
   logic [BYTE_W-1:0] cp_idx;
   logic [PAGE_W-1:0] cp_page;
   logic              cp_bsel;

   // Byte lookup for array or buffer
   function automatic logic [7:0] read_byte(input logic [PAGE_W-1:0] pg,
                                            input logic [BYTE_W-1:0] by,
                                            input logic bm,
                                            input logic bs);
      logic [7:0] val;
      val = ERASED_BYTE;
      if (by <= LAST_BYTE) begin
         if (bm)
            val = bufm[bs][by];
         else
            val = mem[pg][by];
      end
      return val;
   endfunction : read_byte

   //////////////////////////////////////////////////////////////////////////
   // Command decode
   wire [7:0] opcode   = hdr_sr[31:24];
   wire       is_fast  = opcode == OP_FAST_READ;
   wire       is_rand  = opcode == OP_RANDOM_READ;
   wire       is_bfast = opcode == OP_BUF1_FAST || opcode == OP_BUF2_FAST;
   wire       is_bslow = opcode == OP_BUF1_SLOW || opcode == OP_BUF2_SLOW;
   wire       is_b2    = opcode == OP_COPY_BUF2 || opcode == OP_BUF2_FAST ||
                         opcode == OP_BUF2_SLOW;
   wire       b2_ok    = TWO_BUFFERS || !is_b2;
   wire       rd_cmd   = (is_fast || is_rand || is_bfast || is_bslow) && b2_ok;
   wire [5:0] lat_end  = (is_fast || is_bfast) ? DUMMY_END : HDR_END;
   wire       data_go  = rd_cmd && !started && hdr_cnt == lat_end;

   // Copy header is whole at the 32nd rising edge; the last falling edge may
   // coincide with select rising and clearing the header, so capture it here
   wire [31:0] hdr_full = {hdr_sr[30:0], link.mosi};
   wire [7:0]  op_full  = hdr_full[31:24];
   wire        cp_b2    = op_full == OP_COPY_BUF2;
   wire        copy_go  = (op_full == OP_COPY_BUF1 || (cp_b2 && TWO_BUFFERS)) &&
                          hdr_cnt == HDR_END - 6'h01;

   // Start address fields, any page and byte accepted
   wire [PAGE_W-1:0] st_page = hdr_sr[PAGE_LSB +: PAGE_W];
   wire [BYTE_W-1:0] st_byte = hdr_sr[BYTE_W-1:0];

   // Next read location, page advance and array wrap
   wire              pg_end  = rd_byte >= LAST_BYTE;
   wire [BYTE_W-1:0] nx_byte = pg_end ? '0 : BYTE_W'(rd_byte + 9'h001);
   wire [PAGE_W-1:0] nx_page = (pg_end && !rd_buf) ?
                               PAGE_W'(rd_page + 3'h1) : rd_page;
   wire [7:0]        cur_val = read_byte(rd_page, rd_byte, rd_buf, rd_bsel);
   wire [7:0]        nx_val  = read_byte(nx_page, nx_byte, rd_buf, rd_bsel);
   wire [7:0]        st_val  = read_byte(st_page, st_byte, is_bfast || is_bslow, is_b2);

   assign link.miso = miso_q;

   //////////////////////////////////////////////////////////////////////////
   // Header shift on rising edges, cleared when select is high
   always_ff @(posedge link.sck or posedge link.select_n) begin
      if (link.select_n) begin
         hdr_cnt <= 6'h00;
         hdr_sr  <= 32'h0000_0000;
      end else if (hdr_cnt != DUMMY_END) begin
         hdr_cnt <= hdr_cnt + 6'h01;
         if (hdr_cnt < HDR_END)
            hdr_sr <= {hdr_sr[30:0], link.mosi};
      end
   end

   // Data output on falling edges, idle high outside data
   always_ff @(negedge link.sck or posedge link.select_n) begin
      if (link.select_n) begin
         started <= 1'b0;
         bit_idx <= 3'h7;
         rd_page <= '0;
         rd_byte <= '0;
         rd_buf  <= 1'b0;
         rd_bsel <= 1'b0;
         miso_q  <= 1'b1;
      end else if (data_go) begin
         started <= 1'b1;
         bit_idx <= 3'h7;
         rd_page <= st_page;
         rd_byte <= st_byte;
         rd_buf  <= is_bfast || is_bslow;
         rd_bsel <= is_b2;
         miso_q  <= st_val[7];
      end else if (started) begin
         if (bit_idx == 3'h0) begin
            bit_idx <= 3'h7;
            rd_page <= nx_page;
            rd_byte <= nx_byte;
            miso_q  <= nx_val[7];
         end else begin
            bit_idx <= bit_idx - 3'h1;
            miso_q  <= cur_val[bit_idx - 3'h1];
         end
      end
   end

   // Copy request toggle with its page, held until the next copy
   always_ff @(posedge link.sck or posedge rst) begin
      if (rst) begin
         copy_tgl  <= 1'b0;
         copy_page <= '0;
         copy_bsel <= 1'b0;
      end else if (copy_go) begin
         copy_tgl  <= !copy_tgl;
         copy_page <= hdr_full[PAGE_LSB +: PAGE_W];
         copy_bsel <= cp_b2;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Synchronisers for the copy toggle and the select line
   always_ff @(posedge clock) begin
      if (rst) begin
         tgl_s <= 3'h0;
         sel_s <= 2'h3;
      end else begin
         tgl_s <= {tgl_s[1:0], copy_tgl};
         sel_s <= {sel_s[0], link.select_n};
      end
   end

   wire tgl_seen = tgl_s[2] ^ tgl_s[1];
   wire cp_start = (armed || tgl_seen) && sel_s[1] && ready;

   // Arm on a complete copy header, launch after select rises
   always_ff @(posedge clock) begin
      if (rst)
         armed <= 1'b0;
      else if (cp_start)
         armed <= 1'b0;
      else if (tgl_seen)
         armed <= 1'b1;
   end

   // Self-timed page copy, one byte per core clock
   always_ff @(posedge clock) begin
      if (rst) begin
         ready   <= 1'b1;
         cp_idx  <= '0;
         cp_page <= '0;
         cp_bsel <= 1'b0;
      end else if (cp_start) begin
         ready   <= 1'b0;
         cp_idx  <= '0;
         cp_page <= copy_page;
         cp_bsel <= copy_bsel;
      end else if (!ready) begin
         cp_idx <= BYTE_W'(cp_idx + 9'h001);
         if (cp_idx == LAST_BYTE)
            ready <= 1'b1;
      end
   end

   // Array and buffer storage; only the copy writes a buffer
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int p = 0; p < NUM_PAGES; p++)
            for (int b = 0; b < PAGE_BYTES; b++)
               mem[p][b] <= ERASED_BYTE;
         for (int k = 0; k < 2; k++)
            for (int b = 0; b < PAGE_BYTES; b++)
               bufm[k][b] <= ERASED_BYTE;
      end else begin
         if (mem_we && mem_byte <= LAST_BYTE)
            mem[mem_page][mem_byte] <= mem_wdata;
         if (!ready)
            bufm[cp_bsel][cp_idx] <= mem[cp_page][cp_idx];
      end
   end

endmodule : flash_read_device
`default_nettype wire

// >>> rtl/flash_read_host.sv
// Serial link master issuing flash read commands
`timescale 1ns/10ps
`default_nettype none
module flash_read_host
   import flash_read_pkg::*;
(
   input  wire logic        clock,      // System clock
   input  wire logic        rst,        // Synchronous reset
   input  wire logic        start,      // Command start pulse
   input  wire logic [7:0]  opcode,     // Command code
   input  wire logic [23:0] address,    // Start address
   input  wire logic [15:0] byte_count, // Data bytes to read
   output logic             busy,       // Command in progress
   output logic             rd_valid,   // Data byte pulse
   output logic [7:0]       rd_data,    // Received byte
   spi_link_if.host         link        // Serial link
);

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEL  = 2'b01,
      H_RUN  = 2'b10,
      H_STOP = 2'b11
   } host_state_t;

   host_state_t state;
   logic [3:0]  div;
   logic        sck_q;
   logic        sel_q;
   logic        mosi_q;
   logic [39:0] tx;
   logic [19:0] cnt;
   logic [19:0] total;
   logic [19:0] hdr_len;
   logic [1:0]  miso_s;
   logic [7:0]  rx;

   //////////////////////////////////////////////////////////////////////////
   // Frame length from the command
   wire        dummy_w  = opcode == OP_FAST_READ || opcode == OP_BUF1_FAST ||
                          opcode == OP_BUF2_FAST;
   wire        copy_w   = opcode == OP_COPY_BUF1 || opcode == OP_COPY_BUF2;
   wire [19:0] hdr_w    = dummy_w ? HDR_BITS + DUMMY_BITS : HDR_BITS;
   wire [19:0] data_w   = copy_w ? 20'h00000 : {1'b0, byte_count, 3'h0};
   wire        tick     = div == SCK_HALF_M1;
   wire        rise     = state == H_RUN && tick && !sck_q;
   wire [19:0] data_bit = 20'(cnt - hdr_len);

   assign link.sck      = sck_q;
   assign link.select_n = sel_q;
   assign link.mosi     = mosi_q;

   //////////////////////////////////////////////////////////////////////////
   // Serial clock divider, runs only inside a frame
   always_ff @(posedge clock) begin
      if (rst || state == H_IDLE || tick)
         div <= 4'h0;
      else
         div <= div + 4'h1;
   end

   // Frame sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         state  <= H_IDLE;
         sck_q  <= 1'b1;
         sel_q  <= 1'b1;
         mosi_q <= 1'b0;
         busy   <= 1'b0;
         tx     <= 40'h00_0000_0000;
         cnt    <= 20'h00000;
         total  <= 20'h00000;
         hdr_len <= 20'h00000;
      end else begin
         unique case (state)
            H_IDLE: begin
               if (start) begin
                  sel_q   <= 1'b0;
                  busy    <= 1'b1;
                  tx      <= {opcode, address, 8'h00};
                  cnt     <= 20'h00000;
                  hdr_len <= hdr_w;
                  total   <= 20'(hdr_w + data_w);
                  state   <= H_SEL;
               end
            end
            H_SEL: begin
               if (tick) begin
                  sck_q  <= 1'b0;
                  mosi_q <= tx[39];
                  tx     <= {tx[38:0], 1'b0};
                  state  <= H_RUN;
               end
            end
            H_RUN: begin
               if (tick && !sck_q) begin
                  sck_q <= 1'b1;
                  cnt   <= cnt + 20'h00001;
               end else if (tick) begin
                  sck_q <= 1'b0;
                  if (cnt == total) begin
                     sel_q <= 1'b1;
                     state <= H_STOP;
                  end else begin
                     mosi_q <= tx[39];
                     tx     <= {tx[38:0], 1'b0};
                  end
               end
            end
            H_STOP: begin
               if (tick) begin
                  sck_q <= 1'b1;
                  busy  <= 1'b0;
                  state <= H_IDLE;
               end
            end
         endcase
      end
   end

   // Receive path: pin synchroniser, then byte assembly on rising edges
   always_ff @(posedge clock) begin
      if (rst) begin
         miso_s   <= 2'h3;
         rx       <= 8'h00;
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
      end else begin
         miso_s   <= {miso_s[0], link.miso};
         rd_valid <= 1'b0;
         if (rise && cnt >= hdr_len) begin
            rx <= {rx[6:0], miso_s[1]};
            if (data_bit[2:0] == 3'h7) begin
               rd_valid <= 1'b1;
               rd_data  <= {rx[6:0], miso_s[1]};
            end
         end
      end
   end

endmodule : flash_read_host
`default_nettype wire

// >>> rtl/flash_read_pkg.sv
// Shared constants of the serial flash read link
package flash_read_pkg;
   // Command codes
   localparam logic [7:0] OP_FAST_READ   = 8'h0B;
   localparam logic [7:0] OP_RANDOM_READ = 8'h03;
   localparam logic [7:0] OP_COPY_BUF1   = 8'h53;
   localparam logic [7:0] OP_COPY_BUF2   = 8'h55;
   localparam logic [7:0] OP_BUF1_FAST   = 8'hD4;
   localparam logic [7:0] OP_BUF2_FAST   = 8'hD6;
   localparam logic [7:0] OP_BUF1_SLOW   = 8'hD1;
   localparam logic [7:0] OP_BUF2_SLOW   = 8'hD3;
   // Array geometry and address fields
   localparam int         PAGE_BYTES  = 264;
   localparam int         NUM_PAGES   = 8;
   localparam int         BYTE_W      = 9;
   localparam int         PAGE_W      = 3;
   localparam int         PAGE_LSB    = 9;
   localparam logic [8:0] LAST_BYTE   = 9'h107;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // Frame bit counts
   localparam logic [5:0]  HDR_END   = 6'h20;
   localparam logic [5:0]  DUMMY_END = 6'h28;
   localparam logic [19:0] HDR_BITS  = 20'h00020;
   localparam logic [19:0] DUMMY_BITS = 20'h00008;
   // Host serial clock half period in system clocks
   localparam logic [3:0] SCK_HALF_M1 = 4'h4;
endpackage : flash_read_pkg

// >>> rtl/spi_link_if.sv
// Four-wire serial link between flash and master
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
   logic select_n;  // Frame select, low active
   logic sck;       // Serial clock from the master
   logic mosi;      // Master to flash data
   logic miso;      // Flash to master data
   modport device (input select_n, input sck, input mosi, output miso);
   modport host (output select_n, output sck, output mosi, input miso);
endinterface : spi_link_if
`default_nettype wire

// >>> verif/flash_link_checker.sv
// Protocol assertions on the serial link between flash and master
`timescale 1ns/10ps
`default_nettype none
module flash_link_checker
   import flash_read_pkg::*;
(
   input  wire logic clock,    // System clock
   input  wire logic rst,      // Synchronous reset
   input  wire logic select_n, // Frame select, low active
   input  wire logic sck,      // Serial clock
   input  wire logic mosi,     // Master data
   input  wire logic miso      // Flash data
);
   logic [15:0] bits; // Rising serial edges seen in this frame
   logic [7:0]  op;   // Opcode collected from the first eight bits
   wire         has_dummy = (op == OP_FAST_READ) || (op == OP_BUF1_FAST) || (op == OP_BUF2_FAST);
   wire         reads = has_dummy || (op == OP_RANDOM_READ) || (op == OP_BUF1_SLOW) || (op == OP_BUF2_SLOW);
   wire [15:0]  lead = has_dummy ? 16'h0028 : 16'h0020;
   wire [15:0]  tail = bits - lead;
   //////////////////////////////////////////////////////////////////////////////
   // Count serial bits and capture the opcode of the current frame
   always_ff @(posedge clock) begin
      if (rst || select_n) begin
         bits <= 16'h0000;
         op   <= 8'h00;
      end else if ($rose(sck)) begin
         bits <= bits + 16'h0001;
         if (bits < 16'h0008) op <= {op[6:0], mosi};
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Link rules
   chk_idle_miso_high: assert property (@(posedge clock) disable iff (rst) select_n |-> miso)
      else $error("miso low while deselected");
   chk_header_miso_high: assert property (@(posedge clock) disable iff (rst)
      (!select_n && bits < 16'h0020) |-> miso) else $error("miso driven during header");
   chk_dummy_miso_high: assert property (@(posedge clock) disable iff (rst)
      (!select_n && has_dummy && bits < 16'h0028) |-> miso) else $error("miso driven during dummy bits");
   chk_refused_stays_high: assert property (@(posedge clock) disable iff (rst)
      (!select_n && bits >= 16'h0008 && !reads) |-> miso) else $error("data on a command without data");
   chk_miso_on_fall: assert property (@(posedge clock) disable iff (rst)
      (!select_n && $changed(miso)) |-> $fell(sck)) else $error("miso changed off a falling edge");
   chk_mosi_on_fall: assert property (@(posedge clock) disable iff (rst)
      (!select_n && $changed(mosi)) |-> $fell(sck)) else $error("mosi changed off a falling edge");
   chk_select_fall_high: assert property (@(posedge clock) disable iff (rst)
      $fell(select_n) |-> sck) else $error("select fell while clock low");
   chk_select_rise_fall: assert property (@(posedge clock) disable iff (rst)
      $rose(select_n) |-> $fell(sck) ##[1:8] (sck && select_n)) else $error("select rose off a falling edge");
   chk_frame_whole: assert property (@(posedge clock) disable iff (rst)
      $rose(select_n) |-> (bits >= lead && tail[2:0] == 3'h0)) else $error("frame ended mid unit");
endmodule : flash_link_checker
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench: flash read master and device across the link
`timescale 1ns/10ps
`default_nettype none
module tb;
   import flash_read_pkg::*;
   logic              clock, rst, start, start_b, mem_we;
   logic [7:0]        opcode, mem_wdata, rd_data, rd_data_b;
   logic [23:0]       address;
   logic [15:0]       byte_count;
   logic [PAGE_W-1:0] mem_page;
   logic [BYTE_W-1:0] mem_byte;
   logic              busy, busy_b, rd_valid, rd_valid_b, ready, ready_b;
   int                fail_count, check_count, low_a, low_b;
   spi_link_if link_a ();
   spi_link_if link_b ();
   //////////////////////////////////////////////////////////////////////////////
   // Two-buffer pair under check, single-buffer pair beside it
   flash_read_host u_flash_read_host (.clock(clock), .rst(rst), .start(start), .opcode(opcode), .address(address),
      .byte_count(byte_count), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .link(link_a.host));
   flash_read_device u_flash_read_device (.clock(clock), .rst(rst), .mem_we(mem_we), .mem_page(mem_page),
      .mem_byte(mem_byte), .mem_wdata(mem_wdata), .ready(ready), .link(link_a.device));
   flash_read_host u_flash_read_host_single (.clock(clock), .rst(rst), .start(start_b), .opcode(opcode),
      .address(address), .byte_count(byte_count), .busy(busy_b), .rd_valid(rd_valid_b), .rd_data(rd_data_b),
      .link(link_b.host));
   flash_read_device #(.TWO_BUFFERS(1'b0)) u_flash_read_device_single (.clock(clock), .rst(rst), .mem_we(mem_we),
      .mem_page(mem_page), .mem_byte(mem_byte), .mem_wdata(mem_wdata), .ready(ready_b), .link(link_b.device));
   flash_link_checker u_flash_link_checker (.clock(clock), .rst(rst), .select_n(link_a.select_n),
      .sck(link_a.sck), .mosi(link_a.mosi), .miso(link_a.miso));
   //////////////////////////////////////////////////////////////////////////////
   // Clock, busy span counters and watchdog
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(negedge clock) begin
      if (ready === 1'b0) low_a++;
      if (ready_b === 1'b0) low_b++;
   end
   initial begin
      #300_000;
      fail_count++;
      test_done();
   end
   //////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] pat(input int p, input int b);
      return 8'(b) ^ {3'(p), 5'h0A};
   endfunction : pat
   task automatic test_done();
      if (fail_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   task automatic load_array();
      for (int p = 0; p < NUM_PAGES; p++) begin
         for (int b = 0; b < PAGE_BYTES; b++) begin
            @(negedge clock);
            mem_we    = 1'b1;
            mem_page  = 3'(p);
            mem_byte  = 9'(b);
            mem_wdata = pat(p, b);
         end
      end
      @(negedge clock);
      mem_we = 1'b0;
   endtask : load_array
   // One command; mode 0 array, 1 buffer holding page bpg, 2 idle level
   task automatic rd(input bit sel, input logic [7:0] op, input int pg, input int by, input int n,
                     input int mode, input int bpg);
      logic [7:0] got[$];
      logic [7:0] exp;
      int         idx;
      @(negedge clock);
      opcode     = op;
      address    = {12'h000, 3'(pg), 9'(by)};
      byte_count = 16'(n);
      if (sel) start_b = 1'b1;
      else start = 1'b1;
      @(negedge clock);
      start   = 1'b0;
      start_b = 1'b0;
      for (int k = 0; k < 20000; k++) begin
         @(negedge clock);
         if ((sel ? rd_valid_b : rd_valid) === 1'b1) got.push_back(sel ? rd_data_b : rd_data);
         if ((sel ? busy_b : busy) === 1'b0) break;
      end
      check_count++;
      if ((sel ? busy_b : busy) !== 1'b0) begin
         fail_count++;
         $display("[FAIL] %0t frame never ended", $time);
      end
      check_count++;
      if (got.size() != n) begin
         fail_count++;
         $display("[FAIL] %0t got %0d bytes want %0d", $time, got.size(), n);
      end
      foreach (got[i]) begin
         idx = (mode == 0) ? (pg * PAGE_BYTES + by + i) % (NUM_PAGES * PAGE_BYTES)
                           : bpg * PAGE_BYTES + (by + i) % PAGE_BYTES;
         exp = (mode == 2) ? ERASED_BYTE : pat(idx / PAGE_BYTES, idx % PAGE_BYTES);
         check_count++;
         if (got[i] !== exp) begin
            fail_count++;
            $display("[FAIL] %0t op %h byte %0d got %h want %h", $time, op, i, got[i], exp);
         end
      end
   endtask : rd
   task automatic copy(input bit sel, input logic [7:0] op, input int pg, input bit runs);
      low_a = 0;
      low_b = 0;
      rd(sel, op, pg, 0, 0, 0, 0);
      repeat (400) @(negedge clock);
      check_count++;
      if ((sel ? low_b : low_a) != (runs ? PAGE_BYTES : 0)) begin
         fail_count++;
         $display("[FAIL] %0t copy busy span %0d", $time, sel ? low_b : low_a);
      end
   endtask : copy
   //////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      {rst, start, start_b, mem_we} = 4'hF;
      {start, start_b, mem_we} = 3'h0;
      {opcode, address, byte_count} = 48'h0;
      {mem_page, mem_byte, mem_wdata} = 20'h0;
      {fail_count, check_count, low_a, low_b} = 128'h0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      load_array();
      rd(0, OP_BUF1_SLOW, 0, 10, 2, 2, 0);
      rd(0, OP_FAST_READ, 2, 260, 6, 0, 0);
      rd(0, OP_FAST_READ, 4, 0, 1, 0, 0);
      rd(0, OP_RANDOM_READ, 7, 262, 4, 0, 0);
      rd(0, OP_RANDOM_READ, 3, 100, 1, 0, 0);
      rd(0, OP_BUF2_FAST, 0, 5, 1, 2, 0);
      copy(0, OP_COPY_BUF1, 5, 1'b1);
      copy(0, OP_COPY_BUF2, 1, 1'b1);
      rd(0, OP_BUF1_FAST, 0, 262, 3, 1, 5);
      rd(0, OP_FAST_READ, 5, 7, 2, 0, 0);
      rd(0, OP_BUF2_FAST, 0, 0, 2, 1, 1);
      rd(0, OP_BUF1_SLOW, 0, 10, 1, 1, 5);
      rd(0, OP_BUF2_SLOW, 0, 263, 2, 1, 1);
      rd(0, 8'h77, 0, 0, 1, 2, 0);
      copy(1, OP_COPY_BUF2, 1, 1'b0);
      copy(1, OP_COPY_BUF1, 2, 1'b1);
      rd(1, OP_BUF2_FAST, 0, 0, 1, 2, 0);
      rd(1, OP_BUF2_SLOW, 0, 0, 1, 2, 0);
      rd(1, OP_BUF1_SLOW, 0, 7, 1, 1, 2);
      test_done();
   end
endmodule : tb
`default_nettype wire
